// ===== verilog/bscd_pkg.sv
// Purpose: shared constants and carriers for the skip/call/clear decoder
// Assumes: 12-bit instruction words, 11-bit program counter, 8-bit data
// Notes:   status bit 2 is the zero flag; bits 6:5 are the page select
package bscd_pkg;
    localparam int          INSN_W       = 12;
    localparam int          PC_W         = 11;
    localparam int          DATA_W       = 8;
    localparam logic [3:0]  OP_SKIP_SET  = 4'h7;
    localparam logic [3:0]  OP_CALL      = 4'h9;
    localparam logic [11:0] WORD_CLR_W   = 12'h040;
    localparam logic [11:0] WORD_NOP     = 12'h000;
    localparam int          OPC_HI       = 11;
    localparam int          OPC_LO       = 8;
    localparam int          BIT_HI       = 7;
    localparam int          BIT_LO       = 5;
    localparam int          REG_HI       = 4;
    localparam int          REG_LO       = 0;
    localparam int          K_HI         = 7;
    localparam int          K_LO         = 0;
    localparam int          ST_PAGE_HI   = 6;
    localparam int          ST_PAGE_LO   = 5;
    localparam int          ST_ZERO      = 2;
    localparam logic [10:0] PC_RESET     = 11'h7ff;
    localparam logic [7:0]  DATA_ZERO    = 8'h00;

    // decoded form of one instruction word
    typedef struct packed {
        logic       skip_set;
        logic       call;
        logic       clr_w;
        logic [2:0] bit_sel;
        logic [4:0] reg_sel;
        logic [7:0] k;
    } bscd_dec_t;

    // return-stack push request
    typedef struct packed {
        logic             push;
        logic [PC_W-1:0]  addr;
    } bscd_push_t;
endpackage

// ===== verilog/bscd_decode.sv
// Purpose: pure decode of an instruction word into operation fields
// Assumes: word is stable during the cycle it is executed
// Notes:   combinational leaf, the top registers everything it uses
`timescale 1ns/1ps
`default_nettype none
module bscd_decode (
    input  wire logic [11:0]         word_i,
    output var bscd_pkg::bscd_dec_t  dec_o
);
    // opcode match on the top nibble, clear-w on the whole word
    always_comb begin
        dec_o          = '0;
        dec_o.skip_set = (word_i[bscd_pkg::OPC_HI:bscd_pkg::OPC_LO] == bscd_pkg::OP_SKIP_SET);
        dec_o.call     = (word_i[bscd_pkg::OPC_HI:bscd_pkg::OPC_LO] == bscd_pkg::OP_CALL);
        dec_o.clr_w    = (word_i == bscd_pkg::WORD_CLR_W);
        dec_o.bit_sel  = word_i[bscd_pkg::BIT_HI:bscd_pkg::BIT_LO];
        dec_o.reg_sel  = word_i[bscd_pkg::REG_HI:bscd_pkg::REG_LO];
        dec_o.k        = word_i[bscd_pkg::K_HI:bscd_pkg::K_LO];
    end
endmodule
`default_nettype wire

// ===== verilog/bscd_core.sv
// Purpose: executes bit-test-skip-if-set, subroutine call and clear-work-register
// Assumes: fetch supplies the prefetched word each cycle; register file reads
//          combinationally from reg_addr_o; one cycle per instruction clock
// Notes:   a taken skip and a call flush the prefetch and run a no-operation next cycle
//          reg_addr_o is registered, so the register file answers for the word
//          shown one edge earlier; fetch must present each address a cycle
//          ahead, and holding every word for two cycles is the simplest way
//          the counter still advances in the flushed slot, so execution after
//          a taken skip resumes two words past the skip
//          a call only requests the push; the return stack itself lives outside
//          status_i is read on the call's own edge, not in the no-op slot
//          only the zero flag has a write strobe, so no other flag is ever written
//          call walk: edge 1 pushes the return address, loads the target and
//          flags the discard; edge 2 runs the no-op slot and steps the counter
//          skip walk: edge 1 tests the bit and flags the discard when it is set;
//          edge 2 runs the no-op slot, so a taken skip costs one extra cycle
//
// How it works
// - top nibble 0111 tests bit, skips if set
// - taken skip flushes prefetch, runs no-operation, two cycles
// - call pushes program counter plus one first
// - call loads immediate into counter bits 7:0
// - call copies status 6:5 into counter 10:9
// - call clears counter bit 8, two cycles
`timescale 1ns/1ps
`default_nettype none
module bscd_core (
    // clock and reset
    input  wire logic                  ref_clk_i,
    input  wire logic                  resetn_i,
    // fetch, register file and status inputs
    input  wire logic [11:0]           insn_i,
    input  wire logic [7:0]            reg_data_i,
    input  wire logic [7:0]            status_i,
    // register file read address, registered one edge ahead
    output logic      [4:0]            reg_addr_o,
    // program counter and return-stack push request
    output logic      [10:0]           pc_o,
    output var bscd_pkg::bscd_push_t   push_o,
    // working register and zero flag writes
    output logic                       w_we_o,
    output logic      [7:0]            w_data_o,
    output logic                       zero_we_o,
    output logic                       zero_o,
    // pipeline view: discard marker and the word that executed
    output logic                       flush_o,
    output logic      [11:0]           exec_word_o
);
    // two-state view: normal execute, or the flushed no-operation slot
    typedef enum logic [0:0] {
        BSCD_EXEC  = 1'b0,
        BSCD_FLUSH = 1'b1
    } bscd_state_t;

    // whole state of the executor; each top-level output is one field of it
    typedef struct packed {
        // sequencing
        bscd_state_t          state;
        logic [10:0]          pc;
        bscd_pkg::bscd_push_t push;
        // working register and zero flag writes
        logic                 w_we;
        logic [7:0]           w_data;
        logic                 zero_we;
        logic                 zero;
        // pipeline view
        logic                 flush;
        logic [11:0]          word;
        logic [4:0]           reg_addr;
    } bscd_st_t;

    // registered state and its next value
    bscd_st_t             st_q;
    bscd_st_t             st_d;

    // decode and execute helpers, all combinational
    bscd_pkg::bscd_dec_t  dec;
    logic [11:0]          cur_word;
    logic                 live;
    logic [7:0]           bit_hit;
    logic                 bit_set;

    // operation select and the values each operation writes
    logic                 skip_take;
    logic                 call_take;
    logic                 clr_take;
    logic [10:0]          pc_inc;
    logic [1:0]           page_sel;
    logic [10:0]          call_target;
    bscd_pkg::bscd_push_t push_req;
    logic [4:0]           next_addr;

    // a slot is live unless the previous instruction discarded its word
    assign live = (st_q.state == BSCD_EXEC);

    // the word executing now is the prefetched one unless it was discarded
    assign cur_word = live ? insn_i : bscd_pkg::WORD_NOP;

    // field split of the executing word
    bscd_decode u_dec (
        .word_i (cur_word),
        .dec_o  (dec)
    );

    // one tap per data bit; the decoded bit number enables exactly one tap
    for (genvar i = 0; i < bscd_pkg::DATA_W; i++) begin : g_bit
        assign bit_hit[i] = reg_data_i[i] & (dec.bit_sel == 3'(i));
    end

    // the tested bit; reg_data_i answers for reg_addr_o, loaded one edge ahead
    assign bit_set = |bit_hit;

    // which operation this slot carries out; a discarded slot decodes as a no-op
    assign skip_take = dec.skip_set & bit_set;
    assign call_take = dec.call;
    assign clr_take  = dec.clr_w;

    // sequential successor, which is also the return address of a call
    assign pc_inc = st_q.pc + 11'h001;

    // page select is read from status on the call's own edge
    assign page_sel = status_i[bscd_pkg::ST_PAGE_HI:bscd_pkg::ST_PAGE_LO];

    // call target: page bits on top, bit 8 forced low, low byte from the word
    assign call_target = {page_sel,
                          1'b0,
                          dec.k};

    // push request built apart so it carries the counter before the jump
    assign push_req = '{push: call_take, addr: pc_inc};

    // the read address follows the newest fetched word, live slot or not
    assign next_addr = insn_i[bscd_pkg::REG_HI:bscd_pkg::REG_LO];

    // next-state logic; strobes default low, so flags hold unless clear-work runs
    always_comb begin
        // pulsed outputs fall back to idle every cycle
        st_d          = st_q;
        st_d.push     = '0;
        st_d.w_we     = 1'b0;
        st_d.zero_we  = 1'b0;
        st_d.flush    = 1'b0;
        // pipeline bookkeeping follows the fetch every cycle
        st_d.word     = cur_word;
        st_d.reg_addr = next_addr;
        st_d.state    = BSCD_EXEC;
        st_d.pc       = pc_inc;
        case (st_q.state)
            BSCD_EXEC: begin
                if (skip_take) begin
                    // discard the prefetched word; the no-op slot is the second cycle
                    st_d.flush = 1'b1;
                    st_d.state = BSCD_FLUSH;
                end else if (call_take) begin
                    // return address goes out on the same edge the counter jumps
                    st_d.push  = push_req;
                    st_d.pc    = call_target;
                    st_d.flush = 1'b1;
                    st_d.state = BSCD_FLUSH;
                end else if (clr_take) begin
                    // working register cleared and the zero flag written high
                    st_d.w_we    = 1'b1;
                    st_d.w_data  = bscd_pkg::DATA_ZERO;
                    st_d.zero_we = 1'b1;
                    st_d.zero    = 1'b1;
                end
            end

            BSCD_FLUSH: begin
                // the no-op slot writes nothing and returns to normal execution
                st_d.state = BSCD_EXEC;
            end

            default: begin
                // unreachable with a one-bit state; recover to execute
                st_d.state = BSCD_EXEC;
            end
        endcase
    end

    // single state register, synchronous active-low reset
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            // idle control, counter at its reset vector
            st_q.state    <= BSCD_EXEC;
            st_q.pc       <= bscd_pkg::PC_RESET;
            st_q.push     <= '0;
            st_q.flush    <= 1'b0;
            // no pending writes; data paths cleared
            st_q.w_we     <= 1'b0;
            st_q.w_data   <= bscd_pkg::DATA_ZERO;
            st_q.zero_we  <= 1'b0;
            st_q.zero     <= 1'b0;
            // nothing has executed yet and nothing is being read ahead
            st_q.word     <= bscd_pkg::WORD_NOP;
            st_q.reg_addr <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // program counter and return-stack side
    assign pc_o        = st_q.pc;
    assign push_o      = st_q.push;

    // working register and zero flag side
    assign w_we_o      = st_q.w_we;
    assign w_data_o    = st_q.w_data;
    assign zero_we_o   = st_q.zero_we;
    assign zero_o      = st_q.zero;

    // pipeline side: discard marker and the word that executed
    assign flush_o     = st_q.flush;
    assign exec_word_o = st_q.word;

    // read address for the register file, one word ahead
    assign reg_addr_o  = st_q.reg_addr;
endmodule
`default_nettype wire

// ===== tb/bscd_core_assertions.sv
// Purpose: port-level checks for the skip/call/clear executor
// Assumes: one clock domain, sync active-low reset
// Notes:   helper copies hold last-cycle inputs so checks avoid deep $past
`timescale 1ns/1ps
`default_nettype none
module bscd_core_assertions (
    input wire logic                 ref_clk_i,
    input wire logic                 resetn_i,
    input wire logic [11:0]          insn_i,
    input wire logic [7:0]           reg_data_i,
    input wire logic [7:0]           status_i,
    input wire logic [4:0]           reg_addr_o,
    input wire logic [10:0]          pc_o,
    input wire bscd_pkg::bscd_push_t push_o,
    input wire logic                 w_we_o,
    input wire logic [7:0]           w_data_o,
    input wire logic                 zero_we_o,
    input wire logic                 zero_o,
    input wire logic                 flush_o,
    input wire logic [11:0]          exec_word_o
);
    logic [11:0] ins_q;
    logic [7:0]  st_q;
    logic [7:0]  dat_q;
    logic [10:0] pc_q;
    // last-cycle copies; only read one edge after a qualified antecedent
    always_ff @(posedge ref_clk_i) begin
        ins_q <= insn_i;
        st_q  <= status_i;
        dat_q <= reg_data_i;
        pc_q  <= pc_o;
    end
    wire go = resetn_i && !flush_o; // a slot after flush is discarded
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    sequence s_skip; go && insn_i[11:8] == 4'h7 && reg_addr_o == insn_i[4:0]; endsequence
    sequence s_call; go && insn_i[11:8] == 4'h9; endsequence
    sequence s_clr;  go && insn_i == 12'h040; endsequence
    chk_skip_test: assert property (s_skip |=> flush_o == dat_q[ins_q[7:5]])
        else $error("skip decision wrong");
    chk_skip_nop: assert property (flush_o |=> exec_word_o == 12'h000 && !push_o.push && !w_we_o)
        else $error("flushed slot not idle");
    chk_call_ret: assert property (s_call |=> push_o.push && push_o.addr == pc_q + 11'h1)
        else $error("return address wrong");
    chk_call_low: assert property (s_call |=> pc_o[7:0] == ins_q[7:0])
        else $error("call low target wrong");
    chk_call_page: assert property (s_call |=> pc_o[10:9] == st_q[6:5])
        else $error("call page wrong");
    chk_call_two: assert property (s_call |=> flush_o && !pc_o[8])
        else $error("call bit 8 or flush wrong");
    chk_clr_work: assert property (s_clr |=> w_we_o && w_data_o == 8'h00 && zero_we_o && zero_o)
        else $error("clear work wrong");
    chk_keep_flags: assert property (s_skip or s_call |=> !zero_we_o)
        else $error("flags touched");
endmodule
bind bscd_core bscd_core_assertions u_chk (
    .ref_clk_i   (ref_clk_i),
    .resetn_i    (resetn_i),
    .insn_i      (insn_i),
    .reg_data_i  (reg_data_i),
    .status_i    (status_i),
    .reg_addr_o  (reg_addr_o),
    .pc_o        (pc_o),
    .push_o      (push_o),
    .w_we_o      (w_we_o),
    .w_data_o    (w_data_o),
    .zero_we_o   (zero_we_o),
    .zero_o      (zero_o),
    .flush_o     (flush_o),
    .exec_word_o (exec_word_o)
);
`default_nettype wire

// ===== tb/bit_skip_call_clear_decode_tb.sv
// Purpose: directed bench for skip, call and clear-work execution
// Assumes: register file modelled as a pattern keyed by reg_addr_o
// Notes:   bench tracks pc and the discard flag itself
`timescale 1ns/1ps
`default_nettype none
module bit_skip_call_clear_decode_tb;
    logic ref_clk_i, resetn_i, kill, clr, cl;
    logic [11:0] insn_i;
    logic [7:0] status_i, reg_data_i, w_data_o;
    logic [10:0] pc_o, pc, nx;
    logic [4:0] reg_addr_o;
    logic w_we_o, zero_we_o, zero_o, flush_o, f;
    logic [11:0] exec_word_o;
    bscd_pkg::bscd_push_t push_o;
    int n_mismatch, comparisons;
    // combinational register read; wrong address gives wrong bit
    assign reg_data_i = 8'ha5 ^ {3'h0, reg_addr_o};
    bscd_core u_dut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .insn_i(insn_i), .reg_data_i(reg_data_i),
        .status_i(status_i), .reg_addr_o(reg_addr_o), .pc_o(pc_o), .push_o(push_o), .w_we_o(w_we_o),
        .w_data_o(w_data_o), .zero_we_o(zero_we_o), .zero_o(zero_o), .flush_o(flush_o), .exec_word_o(exec_word_o));
    task chk(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    // one executing edge; expectations come from the word, not the outputs
    task step(input logic [11:0] w, input logic [7:0] st);
        @(negedge ref_clk_i);
        insn_i = w;
        status_i = st;
        @(posedge ref_clk_i);
        #1;
        cl = !kill && w[11:8] == 4'h9;
        clr = !kill && w == 12'h040;
        f = cl || (!kill && w[11:8] == 4'h7 && (8'ha5 ^ {3'h0, w[4:0]}) >> w[7:5] & 8'h01);
        nx = cl ? {st[6:5], 1'b0, w[7:0]} : pc + 11'h1;
        chk(pc_o, nx);
        chk(flush_o, f);
        chk(exec_word_o, kill ? 12'h000 : w);
        chk(reg_addr_o, w[4:0]);
        chk(push_o.push, cl);
        if (cl) chk(push_o.addr, pc + 11'h1);
        chk({w_we_o, zero_we_o, zero_o & zero_we_o}, {3{clr}});
        if (clr) chk(w_data_o, 8'h00);
        pc = nx;
        kill = f;
    endtask
    task t_skip;
        for (int b = 0; b < 8; b++) begin
            step({7'h0, 5'(b * 3 + 1)}, 8'h00);
            step({4'h7, 3'(b), 5'(b * 3 + 1)}, 8'h00);
            step(12'h040, 8'h00);
        end
        $display("test skip done");
    endtask
    task t_call;
        for (int p = 0; p < 4; p++) begin
            step({4'h9, 8'(p * 85)}, {1'b0, 2'(p), 5'h1f});
            step(12'h9c3, 8'h60);
            step(12'h040, 8'hff);
        end
        $display("test call done");
    endtask
    task end_sim;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        ref_clk_i = 0;
        forever #20 ref_clk_i = ~ref_clk_i;
    end
    // watchdog sized well past the few dozen cycles the tests need
    initial begin
        #(40 * 2000);
        n_mismatch++;
        end_sim();
    end
    initial begin
        {resetn_i, insn_i, status_i, kill} = '0;
        pc = 11'h7ff;
        repeat (6) @(negedge ref_clk_i);
        resetn_i = 1;
        // the first edge after release already runs the idle word on insn_i
        @(posedge ref_clk_i);
        pc = pc + 11'h001;
        t_skip();
        t_call();
        end_sim();
    end
endmodule
`default_nettype wire
